// file: src/timer_clk_pkg.sv
// Constants for the timer clock source, prescaler and overflow logic
package timer_clk_pkg;
    // Register byte offsets
    localparam logic [7:0] GTC_OFFSET    = 8'h00;
    localparam logic [7:0] CTRL_OFFSET   = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] COUNT_OFFSET  = 8'h0C;
    localparam logic [7:0] TOP_OFFSET    = 8'h10;
    // general_timer_control fields
    localparam int GTC_SYNC_HOLD_BIT = 7;
    localparam int GTC_PSR_BIT       = 0;
    localparam logic [7:0] GTC_RESET = 8'h00;
    // Control, status, count and top register fields and limits
    localparam int CTRL_CS_LSB    = 0;
    localparam int CTRL_WGM_LSB   = 3;
    localparam int CTRL_OVIE_BIT  = 6;
    localparam int CTRL_GIE_BIT   = 7;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam int STATUS_OVF_BIT = 0;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] TOP_RESET   = 8'hFF;
    localparam logic [7:0] COUNT_MAX   = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    // Clock select codes
    localparam logic [2:0] CS_STOP   = 3'h0;
    localparam logic [2:0] CS_DIRECT = 3'h1;
    localparam logic [2:0] CS_DIV8   = 3'h2;
    localparam logic [2:0] CS_DIV64  = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1K  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // Waveform modes
    localparam logic [2:0] WGM_NORMAL    = 3'h0;
    localparam logic [2:0] WGM_PC_MAX    = 3'h1;
    localparam logic [2:0] WGM_CTC       = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX  = 3'h3;
    localparam logic [2:0] WGM_PC_TOP    = 3'h5;
    localparam logic [2:0] WGM_FAST_TOP  = 3'h7;
    // Prescaler: tap N fires when the low log2(N) bits are all ones
    localparam int PRE_WIDTH = 10;
    localparam int TAP8_BITS   = 3;
    localparam int TAP64_BITS  = 6;
    localparam int TAP256_BITS = 8;
    localparam int TAP1K_BITS  = 10;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: src/ext_pin_edge.sv
// Count pin synchroniser and edge detector
`timescale 1ns/1ps
module ext_pin_edge (
    input  wire logic CLK,
    input  wire logic SRST,
    input  wire logic PIN,
    output logic      RISE,
    output logic      FALL
);
    logic sync1_reg, sync2_reg, last_reg;
    logic sync1_next, sync2_next, last_next;

    // Second flop stands in for the clock-high transparent latch
    always_comb begin
        sync1_next = PIN;
        sync2_next = sync1_reg;
        last_next  = sync2_reg;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            last_reg  <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            last_reg  <= last_next;
        end
    end

    assign RISE = sync2_reg & ~last_reg;
    assign FALL = ~sync2_reg & last_reg;

    a_edge_delay: assert property (@(posedge CLK) disable iff (SRST)
        $rose(PIN) ##1 PIN |=> RISE)
        else $error("Pin rise not seen as edge two cycles later");
endmodule

// file: src/timer_clk_src.sv
// Timer clock source: prescaler, count pin input, counter and overflow
`timescale 1ns/1ps
// Behaviours
module timer_clk_src
    import timer_clk_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        EXT_COUNT_PIN,
    input  wire logic        VECTOR_ACK,
    output logic             OVF_IRQ,
    output logic             TIMER_TICK
);
    import timer_clk_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Bus write channel
    logic       aw_have_reg, w_have_reg, bvalid_reg;
    logic       awready_reg, wready_reg;
    logic [7:0] awaddr_reg;
    logic [7:0] wdata_reg;
    logic       wlane_reg;
    logic [1:0] bresp_reg;
    logic       aw_have_next, w_have_next, bvalid_next;
    logic       awready_next, wready_next;
    logic [7:0] awaddr_next, wdata_next;
    logic       wlane_next;
    logic [1:0] bresp_next;
    logic       do_write;

    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next  = w_have_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wlane_next   = wlane_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        do_write     = aw_have_reg & w_have_reg & ~bvalid_reg;
        if (S_AXI_AWVALID && awready_reg) begin
            aw_have_next = 1'b1;
            awaddr_next  = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && wready_reg) begin
            w_have_next = 1'b1;
            wdata_next  = S_AXI_WDATA[7:0];
            wlane_next  = S_AXI_WSTRB[0];
        end
        if (do_write) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            case (awaddr_reg)
                GTC_OFFSET, CTRL_OFFSET, STATUS_OFFSET,
                COUNT_OFFSET, TOP_OFFSET: bresp_next = RESP_OKAY;
                default: bresp_next = RESP_SLVERR;
            endcase
        end else if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_next = 1'b0;
        end
        awready_next = ~aw_have_next & ~bvalid_next;
        wready_next  = ~w_have_next & ~bvalid_next;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 8'h00;
            wlane_reg   <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg  <= w_have_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            wlane_reg   <= wlane_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
        end
    end

    // Every field sits in byte lane 0; other lanes are ignored
    logic wr_en;
    assign wr_en = do_write & wlane_reg;
    logic wr_gtc, wr_ctrl, wr_status, wr_count, wr_top;
    assign wr_gtc    = wr_en && (awaddr_reg == GTC_OFFSET);
    assign wr_ctrl   = wr_en && (awaddr_reg == CTRL_OFFSET);
    assign wr_status = wr_en && (awaddr_reg == STATUS_OFFSET);
    assign wr_count  = wr_en && (awaddr_reg == COUNT_OFFSET);
    assign wr_top    = wr_en && (awaddr_reg == TOP_OFFSET);

    ////////////////////////////////////////////////////////////////////
    // Control state and prescaler
    logic                 smode_reg, psr_reg, smode_next, psr_next;
    logic [7:0]           ctrl_reg, top_reg, ctrl_next, top_next;
    logic [PRE_WIDTH-1:0] pre_reg, pre_next;

    always_comb begin
        smode_next = smode_reg;
        psr_next  = psr_reg;
        ctrl_next = ctrl_reg;
        top_next  = top_reg;
        if (!smode_reg) begin
            psr_next = 1'b0;
        end
        if (wr_gtc) begin
            smode_next = wdata_reg[GTC_SYNC_HOLD_BIT];
            // Clearing hold mode drops the reset bit at once
            psr_next = wdata_reg[GTC_SYNC_HOLD_BIT] ?
                       wdata_reg[GTC_PSR_BIT] :
                       (wdata_reg[GTC_PSR_BIT] & ~smode_reg);
        end
        if (wr_ctrl) begin
            ctrl_next = wdata_reg;
        end
        if (wr_top) begin
            top_next = wdata_reg;
        end
        // Counts on regardless of clock select
        pre_next = psr_reg ? '0 : pre_reg + 1'b1;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            smode_reg <= GTC_RESET[GTC_SYNC_HOLD_BIT];
            psr_reg  <= GTC_RESET[GTC_PSR_BIT];
            ctrl_reg <= CTRL_RESET;
            top_reg  <= TOP_RESET;
            pre_reg  <= '0;
        end else begin
            smode_reg <= smode_next;
            psr_reg  <= psr_next;
            ctrl_reg <= ctrl_next;
            top_reg  <= top_next;
            pre_reg  <= pre_next;
        end
    end

    logic [2:0] cs, wgm;
    logic       ovie, gie, hold;
    assign cs   = ctrl_reg[CTRL_CS_LSB +: 3];
    assign wgm  = ctrl_reg[CTRL_WGM_LSB +: 3];
    assign ovie = ctrl_reg[CTRL_OVIE_BIT];
    assign gie  = ctrl_reg[CTRL_GIE_BIT];
    assign hold = smode_reg & psr_reg;

    ////////////////////////////////////////////////////////////////////
    // Tick selection
    logic ext_rise, ext_fall, tick;

    ext_pin_edge u_pin (
        .CLK  (CLK),
        .SRST (SRST),
        .PIN  (EXT_COUNT_PIN),
        .RISE (ext_rise),
        .FALL (ext_fall)
    );

    always_comb begin
        case (cs)
            CS_STOP:     tick = 1'b0;
            CS_DIRECT:   tick = 1'b1;
            CS_DIV8:     tick = &pre_reg[TAP8_BITS-1:0];
            CS_DIV64:    tick = &pre_reg[TAP64_BITS-1:0];
            CS_DIV256:   tick = &pre_reg[TAP256_BITS-1:0];
            CS_DIV1K:    tick = &pre_reg[TAP1K_BITS-1:0];
            CS_EXT_FALL: tick = ext_fall;
            CS_EXT_RISE: tick = ext_rise;
            default:     tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Counter and overflow flag
    logic [7:0] cnt_reg, cnt_next;
    logic       down_reg, down_next, flag_reg, flag_next;
    logic       irq_reg, irq_next, tick_reg, tick_next;
    logic       ovf_evt, step;
    logic [7:0] top_val;

    always_comb begin
        cnt_next  = cnt_reg;
        down_next = down_reg;
        ovf_evt   = 1'b0;
        step      = tick & ~hold;
        top_val   = (wgm == WGM_PC_TOP || wgm == WGM_FAST_TOP ||
                     wgm == WGM_CTC) ? top_reg : COUNT_MAX;
        if (wr_count) begin
            cnt_next = wdata_reg;
        end else if (step) begin
            case (wgm)
                WGM_PC_MAX, WGM_PC_TOP: begin
                    // Phase correct flags at the bottom turn
                    if (down_reg) begin
                        cnt_next = cnt_reg - 1'b1;
                        if (cnt_reg == COUNT_BOTTOM + 8'h01) begin
                            down_next = 1'b0;
                            ovf_evt   = 1'b1;
                        end
                    end else if (cnt_reg >= top_val) begin
                        down_next = 1'b1;
                        cnt_next  = cnt_reg - 1'b1;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                WGM_FAST_MAX, WGM_FAST_TOP: begin
                    if (cnt_reg == top_val) begin
                        cnt_next = COUNT_BOTTOM;
                        ovf_evt  = 1'b1;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                WGM_CTC: begin
                    cnt_next = (cnt_reg == top_val) ? COUNT_BOTTOM :
                               cnt_reg + 1'b1;
                    ovf_evt  = (cnt_reg == COUNT_MAX);
                end
                default: begin
                    cnt_next = cnt_reg + 1'b1;
                    ovf_evt  = (cnt_reg == COUNT_MAX);
                end
            endcase
        end
        flag_next = flag_reg;
        if (VECTOR_ACK || (wr_status && wdata_reg[STATUS_OVF_BIT])) begin
            flag_next = 1'b0;
        end
        // An overflow in the clearing cycle is kept
        if (ovf_evt) begin
            flag_next = 1'b1;
        end
        irq_next  = gie & ovie & flag_reg;
        tick_next = step;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_reg  <= COUNT_RESET;
            down_reg <= 1'b0;
            flag_reg <= 1'b0;
            irq_reg  <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            down_reg <= down_next;
            flag_reg <= flag_next;
            irq_reg  <= irq_next;
            tick_reg <= tick_next;
        end
    end

    assign OVF_IRQ    = irq_reg;
    assign TIMER_TICK = tick_reg;

    ////////////////////////////////////////////////////////////////////
    // Bus read channel
    logic        rvalid_reg, arready_reg, rvalid_next, arready_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (S_AXI_ARVALID && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            case (S_AXI_ARADDR)
                GTC_OFFSET: begin
                    rdata_next = 8'h00;
                    rdata_next[GTC_SYNC_HOLD_BIT] = smode_reg;
                    rdata_next[GTC_PSR_BIT]       = psr_reg;
                end
                CTRL_OFFSET:   rdata_next = ctrl_reg;
                STATUS_OFFSET: rdata_next = {7'h00, flag_reg};
                COUNT_OFFSET:  rdata_next = cnt_reg;
                TOP_OFFSET:    rdata_next = top_reg;
                default: begin
                    rdata_next = 8'h00;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_next = 1'b0;
        end
        arready_next = ~rvalid_next;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b0;
            rdata_reg   <= 8'h00;
            rresp_reg   <= RESP_OKAY;
        end else begin
            rvalid_reg  <= rvalid_next;
            arready_reg <= arready_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY  = wready_reg;
    assign S_AXI_BVALID  = bvalid_reg;
    assign S_AXI_BRESP   = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID  = rvalid_reg;
    assign S_AXI_RRESP   = rresp_reg;
    assign S_AXI_RDATA   = {24'h0000_00, rdata_reg};

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_psr_alone;
        psr_reg && !smode_reg && !wr_gtc;
    endsequence
    sequence s_held;
        hold && !wr_gtc;
    endsequence

    a_psr_self_clear: assert property (@(posedge CLK) disable iff (SRST)
        s_psr_alone |=> !psr_reg)
        else $error("Prescaler reset bit did not clear");
    a_hold_kept: assert property (@(posedge CLK) disable iff (SRST)
        s_held |=> psr_reg ##0 pre_reg == 10'h000)
        else $error("Hold mode lost prescaler reset");
    a_pre_free: assert property (@(posedge CLK) disable iff (SRST)
        !$past(psr_reg) && !$past(SRST)
        |-> pre_reg == $past(pre_reg) + 10'h001)
        else $error("Prescaler did not advance");
    a_stop_still: assert property (@(posedge CLK) disable iff (SRST)
        cs == CS_STOP && !wr_count |=> $stable(cnt_reg))
        else $error("Counter moved with no clock");
    a_direct_step: assert property (@(posedge CLK) disable iff (SRST)
        cs == CS_DIRECT && !hold |=> tick_reg)
        else $error("Direct select did not tick");
    a_tap8_phase: assert property (@(posedge CLK) disable iff (SRST)
        cs == CS_DIV8 && tick |-> pre_reg[2:0] == 3'h7)
        else $error("Divide by eight tick off phase");
    a_irq_gate: assert property (@(posedge CLK) disable iff (SRST)
        ##1 OVF_IRQ == $past(gie && ovie && flag_reg))
        else $error("Interrupt request mismatch");
    a_flag_set: assert property (@(posedge CLK) disable iff (SRST)
        ovf_evt |=> flag_reg)
        else $error("Overflow did not set flag");
    a_flag_clear: assert property (@(posedge CLK) disable iff (SRST)
        VECTOR_ACK && !ovf_evt |=> !flag_reg)
        else $error("Vector did not clear flag");
    a_ext_rise: assert property (@(posedge CLK) disable iff (SRST)
        cs == CS_EXT_RISE && ext_rise && !hold && !wr_count
        |=> tick_reg && cnt_reg != $past(cnt_reg))
        else $error("Pin rise did not step counter");
endmodule

// file: tb/ext_clk_src.sv
// External clock source model driving the timer count pin
`timescale 1ns/1ps
module ext_clk_src (
    input  wire logic CLK,
    input  wire logic RUN,
    output logic      PIN
);
    // Three clocks a half period stays below clk/2.5
    localparam int HALF = 3;
    int cnt = 0;
    initial PIN = 1'b0;
    ////////////////////////////////////////
    // Holds its level when stopped so the select can change safely
    always @(posedge CLK) begin
        if (RUN) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) PIN <= ~PIN;
        end else begin
            cnt <= 0;
        end
    end
endmodule

// file: tb/tb_top.sv
// Register-level testbench for the timer clock source
`timescale 1ns/1ps
module tb_top;
    import timer_clk_pkg::*;
    logic        clk     = 1'b0;
    logic        srst    = 1'b1;
    logic [7:0]  awaddr  = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata   = 32'h0000_0000;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b1;
    logic [7:0]  araddr  = 8'h00;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b1;
    logic        vack    = 1'b0;
    logic        run     = 1'b0;
    logic        pin_d   = 1'b0;
    logic        pin;
    logic        awready, wready, bvalid, arready, rvalid, irq, tick;
    logic [1:0]  bresp, rresp, last_resp;
    logic [31:0] rdata, rd_val;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          ticks = 0, rises = 0, falls = 0;
    int          div_tab [5] = '{1, 8, 64, 256, 1024};

    always #10 clk = ~clk;

    timer_clk_src i_dut (
        .CLK(clk), .SRST(srst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .EXT_COUNT_PIN(pin),
        .VECTOR_ACK(vack), .OVF_IRQ(irq), .TIMER_TICK(tick)
    );

    ext_clk_src i_src (.CLK(clk), .RUN(run), .PIN(pin));

    // Edge counts on the pin give the expected external tick totals
    always @(posedge clk) begin
        pin_d <= pin;
        if (tick === 1'b1) ticks <= ticks + 1;
        if (pin && !pin_d) rises <= rises + 1;
        if (!pin && pin_d) falls <= falls + 1;
    end

    ////////////////////////////////////////
    task stop_test;
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task hang(input int i);
        if (i >= 50) begin
            error_cnt++;
            $display("unexpected at %0t: bus gave no answer", $time);
            stop_test();
        end
    endtask

    // Both tasks are entered just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        last_resp = bresp;
        hang(i);
    endtask

    task automatic rd(input logic [7:0] a);
        int i;
        araddr <= a;
        arvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rd_val = rdata;
        last_resp = rresp;
        hang(i);
    endtask

    task rc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rd_val, exp);
    endtask

    task automatic win(input int n, output int t);
        int t0;
        t0 = ticks;
        repeat (n) @(posedge clk);
        t = ticks - t0;
    endtask

    ////////////////////////////////////////
    initial begin
        int t, t0, r0, f0, k;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        rc(GTC_OFFSET, 32'h0000_0000);
        rc(CTRL_OFFSET, 32'h0000_0000);
        rc(STATUS_OFFSET, 32'h0000_0000);
        rc(COUNT_OFFSET, 32'h0000_0000);
        rc(TOP_OFFSET, 32'h0000_00FF);
        rc(8'h40, 32'h0000_0000);
        chk(32'(last_resp), 32'(RESP_SLVERR));
        wr(8'h40, 32'h0000_0000);
        chk(32'(last_resp), 32'(RESP_SLVERR));
        wr(COUNT_OFFSET, 32'h0000_0055);
        win(300, t);
        chk(32'(t), 32'h0000_0000);
        rc(COUNT_OFFSET, 32'h0000_0055);
        // Any window of 2048 clocks holds a whole number of every tap
        for (k = 0; k < 5; k++) begin
            wr(CTRL_OFFSET, 32'(CS_DIRECT + 3'(k)));
            repeat (4) @(posedge clk);
            win(2048, t);
            chk(32'(t), 32'(2048 / div_tab[k]));
        end
        wr(CTRL_OFFSET, 32'(CS_DIRECT));
        wr(GTC_OFFSET, 32'h0000_00FF);
        rc(GTC_OFFSET, 32'h0000_0081);
        win(64, t);
        chk(32'(t), 32'h0000_0000);
        wr(GTC_OFFSET, 32'h0000_0000);
        rc(GTC_OFFSET, 32'h0000_0000);
        win(64, t);
        chk(32'(t), 32'h0000_0040);
        wr(GTC_OFFSET, 32'h0000_0001);
        rc(GTC_OFFSET, 32'h0000_0000);
        // Release from hold starts the divide-by-64 tap from zero
        wr(GTC_OFFSET, 32'h0000_0081);
        wr(CTRL_OFFSET, 32'(CS_DIV64));
        wr(GTC_OFFSET, 32'h0000_0000);
        win(40, t);
        chk(32'(t), 32'h0000_0000);
        win(40, t);
        chk(32'(t), 32'h0000_0001);
        // Seven pin toggles per pass make rising and falling totals differ
        for (k = 0; k < 2; k++) begin
            wr(CTRL_OFFSET, 32'(k ? CS_EXT_FALL : CS_EXT_RISE));
            t0 = ticks;
            r0 = rises;
            f0 = falls;
            run <= 1'b1;
            repeat (21) @(posedge clk);
            run <= 1'b0;
            repeat (5) @(posedge clk);
            t = k ? falls - f0 : rises - r0;
            chk(32'(ticks - t0), 32'(t));
        end
        wr(CTRL_OFFSET, 32'h0000_0000);
        wr(STATUS_OFFSET, 32'h0000_0001);
        wr(COUNT_OFFSET, 32'h0000_00F0);
        wr(CTRL_OFFSET, 32'h0000_00C1);
        repeat (30) @(posedge clk);
        chk(32'(irq), 32'h0000_0001);
        rc(STATUS_OFFSET, 32'h0000_0001);
        vack <= 1'b1;
        @(posedge clk);
        vack <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        rc(STATUS_OFFSET, 32'h0000_0000);
        wr(CTRL_OFFSET, 32'h0000_0041);
        repeat (300) @(posedge clk);
        rc(STATUS_OFFSET, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0000);
        wr(CTRL_OFFSET, 32'h0000_0040);
        wr(STATUS_OFFSET, 32'h0000_0001);
        rc(STATUS_OFFSET, 32'h0000_0000);
        // Clear-on-top never reaches the maximum, so no overflow there
        wr(TOP_OFFSET, 32'h0000_0020);
        wr(COUNT_OFFSET, 32'h0000_0000);
        wr(CTRL_OFFSET, 32'h0000_0011);
        repeat (300) @(posedge clk);
        rc(STATUS_OFFSET, 32'h0000_0000);
        wr(CTRL_OFFSET, 32'h0000_0039);
        repeat (60) @(posedge clk);
        rc(STATUS_OFFSET, 32'h0000_0001);
        rc(CTRL_OFFSET, 32'h0000_0039);
        // Phase correct flags only once counting down reaches bottom
        wr(CTRL_OFFSET, 32'h0000_0029);
        wr(STATUS_OFFSET, 32'h0000_0001);
        rc(STATUS_OFFSET, 32'h0000_0000);
        repeat (100) @(posedge clk);
        rc(STATUS_OFFSET, 32'h0000_0001);
        stop_test();
    end
endmodule
